// *** rtl/adc_control_registers.sv ***
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Source 000 or 101..111 takes external path; 001..011 amplifiers; 100 DAC output.
// - Channel codes 0..3 connect external inputs 0..3; 4..15 connect nothing.
// - Reference 00 external pin, 01 converter supply, 10 DAC reference.
// - Converter clock is system clock divided by two to the clock select code.
// - Conversion starts only after start goes high then low again.
// - Busy sets on start, clears at completion in the same cycle as the interrupt flag sets.
// - Justify 0 packs result left in high/low bytes; 1 packs it right.
// - Result bytes keep their contents while the converter is disabled.
module adc_control_registers
    import adc_ctrl_pkg::*;
#(
    parameter int RESULT_WIDTH = 12
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [RESULT_WIDTH-1:0] conv_data_i,
    output analog_route_t route_o,
    output logic converter_enable_o,
    output logic conv_clk_en_o,
    output logic conv_sample_o,
    output logic irq_o
);

    logic [7:0] ctrl0_reg, ctrl0_next;
    logic [7:0] ctrl1_reg, ctrl1_next;
    logic [15:0] result_reg, result_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;
    logic irq_stat_reg, irq_stat_next;
    logic irq_mask_reg, irq_mask_next;
    logic irq_reg, irq_next;
    logic busy_reg, busy_next;
    logic [6:0] div_reg, div_next;
    logic [4:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic sample_reg, sample_next;
    analog_route_t route_reg, route_next;

    logic wr_stb;
    logic rd_stb;
    logic done;
    logic [2:0] src;
    logic [3:0] chan;
    logic [1:0] vref;
    logic start_fall;
    logic [6:0] div_mask;

    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
    assign rd_stb = wb_cyc_i && wb_stb_i && !ack_reg;
    assign src = ctrl1_reg[7:5];
    assign vref = ctrl1_reg[4:3];
    assign chan = ctrl0_reg[3:0];
    assign div_mask = 7'(({7'h00, 1'b1} << ctrl1_reg[2:0]) - 8'h01);
    assign done = busy_reg && tick_reg && (tick_cnt_reg == CONV_CLOCKS - 5'h01);

    // Register file and start handshake
    always_comb
    begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        irq_mask_next = irq_mask_reg;
        start_fall = 1'b0;
        if (wr_stb && wb_adr_i == CTRL0_OFFSET)
        begin
            ctrl0_next = wb_dat_i[7:0];
            ctrl0_next[BUSY_BIT] = 1'b0;
            start_fall = ctrl0_reg[START_BIT] && !wb_dat_i[START_BIT];
        end
        if (wr_stb && wb_adr_i == CTRL1_OFFSET)
        begin
            ctrl1_next = wb_dat_i[7:0];
        end
        if (wr_stb && wb_adr_i == IRQ_MASK_OFFSET)
        begin
            irq_mask_next = wb_dat_i[0];
        end
    end

    // Conversion sequencer
    always_comb
    begin
        busy_next = busy_reg;
        result_next = result_reg;
        irq_stat_next = irq_stat_reg;
        div_next = (div_reg & div_mask) == div_mask ? 7'h00 : 7'(div_reg + 7'h01);
        tick_next = busy_reg && ((div_reg & div_mask) == div_mask);
        tick_cnt_next = tick_cnt_reg;
        if (!ctrl0_reg[ENABLE_BIT])
        begin
            busy_next = 1'b0;
            tick_cnt_next = 5'h00;
        end
        else if (start_fall && !busy_reg)
        begin
            busy_next = 1'b1;
            tick_cnt_next = 5'h00;
            div_next = 7'h00;
        end
        else if (done)
        begin
            busy_next = 1'b0;
            irq_stat_next = 1'b1;
            if (ctrl0_reg[JUSTIFY_BIT])
                result_next = {4'h0, conv_data_i};
            else
                result_next = {conv_data_i, 4'h0};
        end
        else if (tick_reg)
        begin
            tick_cnt_next = 5'(tick_cnt_reg + 5'h01);
        end
        // At divide by one the divider is always due; no stray pulse once busy drops
        tick_next = tick_next && busy_next;
        // Set wins over a same-cycle write-one clear
        if (wr_stb && wb_adr_i == IRQ_STATUS_OFFSET && wb_dat_i[0] && !done)
        begin
            irq_stat_next = 1'b0;
        end
        sample_next = busy_next && !busy_reg;
        irq_next = irq_stat_next && irq_mask_next;
    end

    // Analog routing decode
    always_comb
    begin
        route_next = '0;
        if (src == SRC_EXT || src > SRC_DAC)
        begin
            if (chan < EXT_CHANNELS)
                route_next.ext_onehot = 4'(4'h1 << chan[1:0]);
        end
        else if (src == SRC_DAC)
        begin
            route_next.dac_out_sel = 1'b1;
        end
        else
        begin
            route_next.amp_onehot = 3'(3'h1 << 2'(src - SRC_AMP0));
        end
        route_next.ref_supply_sel = vref == REF_SUPPLY;
        route_next.ref_dac_sel = vref == REF_DAC;
        route_next.ref_pin_sel = vref != REF_SUPPLY && vref != REF_DAC;
    end

    // Bus answer
    always_comb
    begin
        ack_next = rd_stb;
        dat_next = 32'h0000_0000;
        if (rd_stb && !wb_we_i)
        begin
            unique case (wb_adr_i)
                CTRL0_OFFSET: dat_next = {24'h0000_00, ctrl0_reg[7], busy_reg, ctrl0_reg[5:0]};
                CTRL1_OFFSET: dat_next = {24'h0000_00, ctrl1_reg};
                RESULT_OFFSET: dat_next = {16'h0000, result_reg};
                IRQ_STATUS_OFFSET: dat_next = {31'h0, irq_stat_reg};
                IRQ_MASK_OFFSET: dat_next = {31'h0, irq_mask_reg};
                default: dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl0_reg <= CTRL_RESET;
            ctrl1_reg <= CTRL_RESET;
            result_reg <= 16'h0000;
            dat_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            irq_stat_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
            irq_reg <= 1'b0;
            busy_reg <= 1'b0;
            div_reg <= 7'h00;
            tick_cnt_reg <= 5'h00;
            tick_reg <= 1'b0;
            sample_reg <= 1'b0;
            route_reg <= '0;
        end
        else
        begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            result_reg <= result_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
            busy_reg <= busy_next;
            div_reg <= div_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            sample_reg <= sample_next;
            route_reg <= route_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign route_o = route_reg;
    assign converter_enable_o = ctrl0_reg[ENABLE_BIT];
    assign conv_clk_en_o = tick_reg;
    assign conv_sample_o = sample_reg;
    assign irq_o = irq_reg;

    property p_route_internal;
        @(posedge clk_i) disable iff (rst_i)
        (src == SRC_DAC) |=> route_reg.dac_out_sel && route_reg.ext_onehot == 4'h0;
    endproperty
    a_route_internal: assert property (p_route_internal) else $error("dac source not routed");

    property p_float;
        @(posedge clk_i) disable iff (rst_i)
        (chan >= EXT_CHANNELS) |=> route_reg.ext_onehot == 4'h0;
    endproperty
    a_float: assert property (p_float) else $error("pinless channel drove a pin");

    property p_ref;
        @(posedge clk_i) disable iff (rst_i)
        (vref == REF_SUPPLY) |=> route_reg.ref_supply_sel && !route_reg.ref_pin_sel;
    endproperty
    a_ref: assert property (p_ref) else $error("supply reference not selected");

    sequence s_start_pulse;
        ctrl0_reg[ENABLE_BIT] && !busy_reg && start_fall;
    endsequence

    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        s_start_pulse |=> busy_reg;
    endproperty
    a_start: assert property (p_start) else $error("busy not set after start pulse");

    property p_done;
        @(posedge clk_i) disable iff (rst_i)
        done && ctrl0_reg[ENABLE_BIT] |=> !busy_reg && irq_stat_reg;
    endproperty
    a_done: assert property (p_done) else $error("completion flags wrong");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        !ctrl0_reg[ENABLE_BIT] |=> $stable(result_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed while disabled");

    property p_off;
        @(posedge clk_i) disable iff (rst_i)
        !ctrl0_reg[ENABLE_BIT] |=> !busy_reg;
    endproperty
    a_off: assert property (p_off) else $error("busy while disabled");

    property p_justify;
        @(posedge clk_i) disable iff (rst_i)
        done && ctrl0_reg[ENABLE_BIT] && !ctrl0_reg[JUSTIFY_BIT] |=> result_reg[3:0] == 4'h0;
    endproperty
    a_justify: assert property (p_justify) else $error("left justified low nibble not zero");

endmodule : adc_control_registers

// *** rtl/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

    // Register word offsets (byte addresses on the 32-bit bus)
    localparam logic [4:0] CTRL0_OFFSET = 5'h00;
    localparam logic [4:0] CTRL1_OFFSET = 5'h04;
    localparam logic [4:0] RESULT_OFFSET = 5'h08;
    localparam logic [4:0] IRQ_STATUS_OFFSET = 5'h0c;
    // Mask needs its own word; a 4-bit address would fold it onto control 0
    localparam logic [4:0] IRQ_MASK_OFFSET = 5'h10;

    // Control register 0 bit positions
    localparam int START_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int ENABLE_BIT = 5;
    localparam int JUSTIFY_BIT = 4;

    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Input source codes
    localparam logic [2:0] SRC_EXT = 3'h0;
    localparam logic [2:0] SRC_AMP0 = 3'h1;
    localparam logic [2:0] SRC_AMP2 = 3'h3;
    localparam logic [2:0] SRC_DAC = 3'h4;

    // Number of external channels wired to pins
    localparam logic [3:0] EXT_CHANNELS = 4'h4;

    // Reference codes
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_DAC = 2'h2;

    // Conversion length in converter clocks
    localparam logic [4:0] CONV_CLOCKS = 5'h10;

    typedef struct packed {
        logic [3:0] ext_onehot;
        logic [2:0] amp_onehot;
        logic dac_out_sel;
        logic ref_pin_sel;
        logic ref_supply_sel;
        logic ref_dac_sel;
    } analog_route_t;

endpackage : adc_ctrl_pkg

// *** verif/adc_control_registers_tb.sv ***
`timescale 1ns/1ps
module adc_control_registers_tb;
    import adc_ctrl_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, converter_enable_o, conv_clk_en_o, conv_sample_o, irq_o;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, res;
    logic [11:0] conv_data_i, dv;
    analog_route_t route_o, er;
    int n_fail, checks, n_pulse, n_samp, gap, last, cyc, p0, s0, s, ch, d;
    adc_control_registers i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .conv_data_i(conv_data_i), .route_o(route_o), .converter_enable_o(converter_enable_o),
        .conv_clk_en_o(conv_clk_en_o), .conv_sample_o(conv_sample_o), .irq_o(irq_o));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Pulse spacing is taken from the last pulse of a run, where the divider is steady
    always @(posedge clk_i)
    begin
        cyc++;
        if (conv_clk_en_o === 1'b1)
        begin
            n_pulse++;
            gap = cyc - last;
            last = cyc;
        end
        if (conv_sample_o === 1'b1)
            n_samp++;
    end
    task final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wb(input logic we, input logic [4:0] a, input logic [31:0] dt, input logic [3:0] se);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dt;
        wb_sel_i <= se;
        for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
            @(posedge clk_i);
        if (i == 20)
        begin
            n_fail++;
            final_report();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task convert(input logic [7:0] c0);
        int i;
        p0 = n_pulse;
        s0 = n_samp;
        wb(1, IRQ_MASK_OFFSET, {31'h0, c0[0]}, 4'hf);
        wb(0, IRQ_MASK_OFFSET, 32'h0000_0000, 4'hf);
        chk("mask", {31'h0, c0[0]}, rd);
        wb(1, CTRL0_OFFSET, {24'h0000_00, c0 | 8'h80}, 4'hf);
        wb(0, CTRL0_OFFSET, 32'h0000_0000, 4'hf);
        chk("busy before fall", 32'h0000_0000, rd[BUSY_BIT]);
        wb(1, CTRL0_OFFSET, {24'h0000_00, c0}, 4'hf);
        wb(0, CTRL0_OFFSET, 32'h0000_0000, 4'hf);
        chk("busy", 32'h0000_0001, rd[BUSY_BIT]);
        for (i = 0; i < 3000 && rd[BUSY_BIT] !== 1'b0; i++)
            wb(0, CTRL0_OFFSET, 32'h0000_0000, 4'hf);
        if (i == 3000)
        begin
            n_fail++;
            final_report();
        end
        chk("clock pulses", CONV_CLOCKS, n_pulse - p0);
        chk("samples", 32'h0000_0001, n_samp - s0);
        wb(0, IRQ_STATUS_OFFSET, 32'h0000_0000, 4'hf);
        chk("status", 32'h0000_0001, rd);
        chk("irq", {31'h0, c0[0]}, irq_o);
        wb(1, IRQ_STATUS_OFFSET, 32'h0000_0001, 4'hf);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 32'h0000_0000, irq_o);
        wb(0, IRQ_STATUS_OFFSET, 32'h0000_0000, 4'hf);
        chk("status cleared", 32'h0000_0000, rd);
    endtask : convert
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {n_fail, checks, n_pulse, n_samp, gap, last, cyc} = '0;
        conv_data_i = 12'h000;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, CTRL0_OFFSET, 32'h0000_0000, 4'hf);
        chk("ctrl0 reset", 32'h0000_0000, rd);
        wb(0, CTRL1_OFFSET, 32'h0000_0000, 4'hf);
        chk("ctrl1 reset", 32'h0000_0000, rd);
        wb(0, 5'h02, 32'h0000_0000, 4'hf);
        chk("unmapped", 32'h0000_0000, rd);
        for (s = 0; s < 8; s++)
            for (ch = 0; ch < 16; ch++)
            begin
                // Internal sources are only paired with pinless channel codes
                if (s > 0 && s < 5 && ch < 4)
                    continue;
                wb(1, CTRL0_OFFSET, ch, 4'hf);
                wb(1, CTRL1_OFFSET, {s[2:0], ch[1:0], 3'h0}, 4'hf);
                wb(0, CTRL1_OFFSET, 32'h0000_0000, 4'hf);
                chk("ctrl1", {s[2:0], ch[1:0], 3'h0}, rd);
                er = '0;
                if ((s == 0 || s > 4) && ch < 4)
                    er.ext_onehot[ch] = 1'b1;
                if (s > 0 && s < 4)
                    er.amp_onehot[s - 1] = 1'b1;
                er.dac_out_sel = (s == 4);
                er.ref_pin_sel = (ch[1:0] == 2'h0 || ch[1:0] == 2'h3);
                er.ref_supply_sel = (ch[1:0] == 2'h1);
                er.ref_dac_sel = (ch[1:0] == 2'h2);
                chk("route", er, route_o);
            end
        wb(1, CTRL1_OFFSET, 32'h0000_00ff, 4'he);
        wb(0, CTRL1_OFFSET, 32'h0000_0000, 4'hf);
        chk("sel refused", 32'h0000_00f8, rd);
        wb(1, CTRL0_OFFSET, 32'h0000_0060, 4'hf);
        wb(0, CTRL0_OFFSET, 32'h0000_0000, 4'hf);
        chk("busy read only", 32'h0000_0020, rd);
        chk("enable out", 32'h0000_0001, converter_enable_o);
        for (d = 0; d < 8; d++)
        begin
            dv = 12'ha53 ^ {9'h000, d[2:0]};
            conv_data_i <= dv;
            wb(1, CTRL1_OFFSET, {29'h0, d[2:0]}, 4'hf);
            convert({3'h1, d[0], 3'h0, ~d[1]});
            chk("divide", 32'h0000_0001 << d, gap);
            wb(0, RESULT_OFFSET, 32'h0000_0000, 4'hf);
            res = d[0] ? {20'h0_0000, dv} : {16'h0000, dv, 4'h0};
            chk("result", res, rd);
        end
        // Disabled converter must neither start nor touch the result
        wb(1, CTRL0_OFFSET, 32'h0000_0011, 4'hf);
        conv_data_i <= 12'h3c5;
        wb(1, CTRL0_OFFSET, 32'h0000_0091, 4'hf);
        wb(1, CTRL0_OFFSET, 32'h0000_0011, 4'hf);
        wb(0, CTRL0_OFFSET, 32'h0000_0000, 4'hf);
        chk("no busy disabled", 32'h0000_0011, rd);
        chk("enable off", 32'h0000_0000, converter_enable_o);
        repeat (40) @(posedge clk_i);
        wb(0, RESULT_OFFSET, 32'h0000_0000, 4'hf);
        chk("result kept", res, rd);
        final_report();
    end
endmodule : adc_control_registers_tb
